// file: core/cbab_pkg.sv
// Constants, encodings and timing counts for the CAN bit-rate bridge node.
// Assumes a 200 MHz system clock; every user of these names writes cbab_pkg::name.
//
// Contract
// - Reset default is autobaud over four presets
// - Local rate may differ from peer rate
// - One-sided traffic: detected rate used by both
// - Unlocked 15 s after link up: adopt peer
// - Neither detected after 15 s: first detector decides
// - Detection waits forever, never abandoned
// - Link loss keeps detected rate, no re-detection
// - Preset sample point between 87% and 89%
// - Own rate selection independent of peer
// - Custom timing: rate, tseg1, tseg2, SJW, silent
// - Compute nearest prescaler from rate and segments
// - Custom timing used only when defined and selected
// - Custom selected but undefined: use 1 Mbit/s
// - Buffer overflow discards, never stalls bus
// - Buffer FIFO: oldest sent and discarded first
// - Up to four identifier/mask acceptance filters
// - Unacknowledged message retried twice, then dropped

package cbab_pkg;

	// ----------------------------------------------------------------
	// Rate selection and preset encodings
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {RATE_1M = 2'h0, RATE_500K = 2'h1,
		RATE_250K = 2'h2, RATE_125K = 2'h3} cbab_rate_e;
	localparam logic [2:0] SEL_AUTO   = 3'h4;  // Reset default selection
	localparam logic [2:0] SEL_CUSTOM = 3'h5;  // Sixth option

	// ----------------------------------------------------------------
	// Bit timing: 8 quanta per bit, sample after 7 (87.5 %)
	// ----------------------------------------------------------------
	localparam int          BRP_W       = 10;
	localparam logic [4:0]  PRE_TSEG1   = 5'h06;
	localparam logic [3:0]  PRE_TSEG2   = 4'h1;
	localparam logic [1:0]  PRE_SJW     = 2'h1;
	localparam logic [9:0]  BRP_1M      = 10'h019;  // 200 MHz / 25 / 8
	localparam logic [9:0]  BRP_500K    = 10'h032;
	localparam logic [9:0]  BRP_250K    = 10'h064;
	localparam logic [9:0]  BRP_125K    = 10'h0c8;
	localparam logic [9:0]  CUST_MAX_KBPS = 10'h3e8;  // 1000 kbit/s
	localparam logic [17:0] CLK_KHZ     = 18'h3_0d40;  // 200000 kHz

	// ----------------------------------------------------------------
	// Timing counts
	// ----------------------------------------------------------------
	localparam longint CLK_HZ       = 200_000_000;
	localparam longint ADOPT_SEC    = 15;
	localparam logic [31:0] ADOPT_CYC = 32'(ADOPT_SEC * CLK_HZ);
	localparam logic [1:0]  MAX_RETRY = 2'h2;

	// ----------------------------------------------------------------
	// Message layout: identifier in the low bits
	// ----------------------------------------------------------------
	localparam int ID_W  = 29;
	localparam int MSG_W = 97;  // 29 id, 4 length, 64 data
	localparam int N_FLT = 4;

endpackage

// file: core/cbab_fifo_if.sv
// Carrier between the node logic and its transmit FIFO.
// Assumes both ends share sys_clk.
`timescale 1ns/100ps
`default_nettype none

interface cbab_fifo_if #(parameter int W = 8);
	logic         in_valid;   // Producer offers a word
	logic         in_ready;   // FIFO takes it
	logic [W-1:0] in_data;
	logic         out_valid;  // FIFO has a head word
	logic         out_ready;  // Consumer pops the head
	logic [W-1:0] out_data;

	modport store (input in_valid, input in_data, output in_ready,
		output out_valid, output out_data, input out_ready);
	modport user (output in_valid, output in_data, input in_ready,
		input out_valid, input out_data, output out_ready);
endinterface

`default_nettype wire

// file: core/cbab_fifo.sv
// First-in first-out store of flip-flops, width and depth set by parameters.
// Assumes a single clock; a pop and a push may share a cycle even when full.
`timescale 1ns/100ps
`default_nettype none

module cbab_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 8
) (
	input  wire logic sys_clk,
	input  wire logic sys_rst,
	cbab_fifo_if.store f
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0]  mem_q [DEPTH];  // Storage
	logic [AW-1:0] wr_q;           // Write index
	logic [AW-1:0] rd_q;           // Read index
	logic [AW:0]   cnt_q;          // Words held
	logic          push;
	logic          pop;

	// Ready is plain not-full, never waiting on the pop, so no loop forms;
	// a push into a full store is still taken when the head leaves
	assign f.out_valid = (cnt_q != '0);
	assign f.in_ready  = (cnt_q != (AW+1)'(DEPTH));
	assign f.out_data  = mem_q[rd_q];
	assign pop         = f.out_valid && f.out_ready;
	assign push        = f.in_valid && (f.in_ready || pop);

	// ----------------------------------------------------------------
	// Indices and occupancy
	// ----------------------------------------------------------------
	// oldest leaves first
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end
		else
		begin
			if (push)
				wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
			if (pop)
				rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// Storage write; contents need no reset
	always_ff @(posedge sys_clk)
	begin
		if (push)
			mem_q[wr_q] <= f.in_data;
	end

endmodule

`default_nettype wire

// file: core/cbab_node.sv
// Top of one bridge node: rate selection, bit timing, filters, transmit queue.
// Assumes an external CAN controller that runs on the bit timing given here and
// reports frames, and a radio link layer that acknowledges each packet.
`timescale 1ns/100ps
`default_nettype none

module cbab_node #(
	parameter logic [31:0] ADOPT_CYC = cbab_pkg::ADOPT_CYC,  // 15 s wait
	parameter int          MSG_W     = cbab_pkg::MSG_W,
	parameter int          DEPTH     = 8,
	parameter int          N_FLT     = cbab_pkg::N_FLT
) (
	input  wire logic                     sys_clk,
	input  wire logic                     sys_rst,
	// Rate configuration
	input  wire logic [2:0]               cfg_rate_sel,
	input  wire logic                     cfg_cust_defined,
	input  wire logic [9:0]               cfg_cust_kbps,
	input  wire logic [4:0]               cfg_cust_tseg1,
	input  wire logic [3:0]               cfg_cust_tseg2,
	input  wire logic [1:0]               cfg_cust_sjw,
	input  wire logic                     cfg_cust_silent,
	// Local controller reports at the current timing
	input  wire logic                     ctl_frame_ok,
	input  wire logic                     ctl_frame_err,
	// Peer and link state
	input  wire logic                     link_up,
	input  wire logic                     peer_rate_valid,
	input  wire logic [1:0]               peer_rate,
	// Acceptance filters
	input  wire logic [N_FLT-1:0]         flt_en,
	input  wire logic [N_FLT*cbab_pkg::ID_W-1:0] flt_id,
	input  wire logic [N_FLT*cbab_pkg::ID_W-1:0] flt_mask,
	// Received local messages
	input  wire logic                     rx_msg_valid,
	input  wire logic [MSG_W-1:0]         rx_msg_data,
	// Radio transmit side
	input  wire logic                     radio_ready,
	input  wire logic                     radio_ack,
	input  wire logic                     radio_nak,
	output logic                          radio_valid_q,
	output logic [MSG_W-1:0]              radio_data_q,
	// Bit timing to the controller
	output logic [cbab_pkg::BRP_W-1:0]    bt_brp_q,
	output logic [4:0]                    bt_tseg1_q,
	output logic [3:0]                    bt_tseg2_q,
	output logic [1:0]                    bt_sjw_q,
	output logic                          bt_silent_q,
	output logic                          bt_valid_q,
	// Status
	output logic                          rate_locked_q,
	output logic [1:0]                    local_rate_q,
	output logic                          rate_from_peer_q,
	output logic                          ovf_drop_q,
	output logic                          retry_drop_q
);

	// ----------------------------------------------------------------
	// Types and decode helpers
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {AB_HUNT = 2'b00, AB_LOCK = 2'b01,
		AB_FIXED = 2'b11} cbab_ab_e;
	typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_SEND = 2'b01,
		TX_WAIT = 2'b11} cbab_tx_e;

	// Prescaler of a preset; all presets share 8 quanta per bit
	function automatic logic [cbab_pkg::BRP_W-1:0] preset_brp(input logic [1:0] r);
		case (r)
			cbab_pkg::RATE_1M:   preset_brp = cbab_pkg::BRP_1M;
			cbab_pkg::RATE_500K: preset_brp = cbab_pkg::BRP_500K;
			cbab_pkg::RATE_250K: preset_brp = cbab_pkg::BRP_250K;
			default:             preset_brp = cbab_pkg::BRP_125K;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Configuration tracking
	// ----------------------------------------------------------------
	cbab_ab_e    ab_q;          // Detection state
	logic [1:0]  try_q;         // Candidate under test
	logic [2:0]  sel_q;         // Last seen selection
	logic        restart;       // Selection changed
	logic        cust_ok;       // Custom set fully defined
	logic        cust_use;      // Custom timing in force
	logic [31:0] pwr_cnt_q;     // Time since reset
	logic [31:0] link_cnt_q;    // Time since link up
	logic        pwr_exp;
	logic        link_exp;

	assign restart  = (cfg_rate_sel != sel_q);
	assign cust_ok  = cfg_cust_defined && (cfg_cust_kbps != '0)
		&& (cfg_cust_kbps <= cbab_pkg::CUST_MAX_KBPS)
		&& (cfg_cust_tseg1 != '0) && (cfg_cust_tseg2 != '0)
		&& (cfg_cust_sjw != '0);
	assign cust_use = (ab_q == AB_FIXED) && (sel_q == cbab_pkg::SEL_CUSTOM) && cust_ok;
	assign pwr_exp  = (pwr_cnt_q >= ADOPT_CYC);
	assign link_exp = (link_cnt_q >= ADOPT_CYC);

	// Selection register; reset matches autobaud so no restart at start
	// own selection only
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			sel_q <= cbab_pkg::SEL_AUTO;
		else
			sel_q <= cfg_rate_sel;
	end

	// ----------------------------------------------------------------
	// Adoption timers, saturating
	// ----------------------------------------------------------------
	// power-up wait
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			pwr_cnt_q <= '0;
		else if (!pwr_exp)
			pwr_cnt_q <= pwr_cnt_q + 32'h0000_0001;
	end

	// link-up wait, restarts whenever the link drops
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst || !link_up)
			link_cnt_q <= '0;
		else if (!link_exp)
			link_cnt_q <= link_cnt_q + 32'h0000_0001;
	end

	// ----------------------------------------------------------------
	// Rate detection state machine
	// ----------------------------------------------------------------
	// autobaud from reset
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			ab_q             <= AB_HUNT;
			try_q            <= cbab_pkg::RATE_1M;
			rate_locked_q    <= 1'b0;
			local_rate_q     <= cbab_pkg::RATE_1M;
			rate_from_peer_q <= 1'b0;
		end
		else if (restart)
		begin
			// New selection: start over, presets lock at once
			rate_from_peer_q <= 1'b0;
			try_q            <= cbab_pkg::RATE_1M;
			if (cfg_rate_sel == cbab_pkg::SEL_AUTO)
			begin
				ab_q          <= AB_HUNT;
				rate_locked_q <= 1'b0;
			end
			else
			begin
				ab_q          <= AB_FIXED;
				rate_locked_q <= 1'b1;
				local_rate_q  <= (cfg_rate_sel[2]) ? cbab_pkg::RATE_1M : cfg_rate_sel[1:0];
			end
		end
		else
		begin
			case (ab_q)
				AB_HUNT:
				begin
					if (ctl_frame_ok)
					begin
						ab_q          <= AB_LOCK;
						rate_locked_q <= 1'b1;
						local_rate_q  <= try_q;
					end
					else if (peer_rate_valid && (link_exp || pwr_exp))
					begin
						ab_q             <= AB_LOCK;
						rate_locked_q    <= 1'b1;
						local_rate_q     <= peer_rate;
						rate_from_peer_q <= 1'b1;
					end
					else if (ctl_frame_err)
						try_q <= try_q + 2'h1;
				end
				AB_LOCK:  ab_q <= AB_LOCK;
				AB_FIXED: ab_q <= AB_FIXED;
				default:  ab_q <= AB_HUNT;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Custom prescaler by repeated subtraction
	// ----------------------------------------------------------------
	// Iterative divide costs up to a thousand cycles once per change but
	// avoids a wide combinational divider in the timing path.
	logic [17:0] key_q;         // Rate, tseg2 and low four tseg1 bits last computed
	logic [17:0] key;
	logic [17:0] rem_q;         // Remaining numerator
	logic [14:0] den_q;         // Rate times quanta per bit
	logic [cbab_pkg::BRP_W-1:0] quo_q;
	logic        busy_q;
	logic [4:0]  ntq;
	logic [14:0] den;

	assign key = {cfg_cust_kbps, cfg_cust_tseg1[3:0], cfg_cust_tseg2};
	assign ntq = 5'h01 + cfg_cust_tseg1 + {1'b0, cfg_cust_tseg2};
	assign den = 15'(cfg_cust_kbps * ntq);

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			key_q  <= '0;
			rem_q  <= '0;
			den_q  <= '0;
			quo_q  <= '0;
			busy_q <= 1'b0;
		end
		else if (key != key_q || restart)
		begin
			// Rounded: numerator carries half a divisor
			key_q  <= key;
			den_q  <= den;
			rem_q  <= cbab_pkg::CLK_KHZ + 18'({1'b0, den[14:1]});
			quo_q  <= '0;
			busy_q <= cust_ok;
		end
		else if (busy_q)
		begin
			if (rem_q >= {3'h0, den_q} && quo_q != '1)
			begin
				rem_q <= rem_q - {3'h0, den_q};
				quo_q <= quo_q + 1'b1;
			end
			else
				busy_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Bit timing outputs
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			bt_brp_q    <= cbab_pkg::BRP_1M;
			bt_tseg1_q  <= cbab_pkg::PRE_TSEG1;
			bt_tseg2_q  <= cbab_pkg::PRE_TSEG2;
			bt_sjw_q    <= cbab_pkg::PRE_SJW;
			bt_silent_q <= 1'b1;
			bt_valid_q  <= 1'b0;
		end
		else if (cust_use)
		begin
			bt_brp_q    <= (quo_q == '0) ? cbab_pkg::BRP_W'(1) : quo_q;
			bt_tseg1_q  <= cfg_cust_tseg1;
			bt_tseg2_q  <= cfg_cust_tseg2;
			bt_sjw_q    <= cfg_cust_sjw;
			bt_silent_q <= cfg_cust_silent || restart;
			// Stale prescaler is never shown as valid while a change waits
			bt_valid_q  <= !busy_q && !restart && (key == key_q);
		end
		else
		begin
			bt_brp_q    <= preset_brp((ab_q == AB_HUNT) ? try_q : local_rate_q);
			bt_tseg1_q  <= cbab_pkg::PRE_TSEG1;
			bt_tseg2_q  <= cbab_pkg::PRE_TSEG2;
			bt_sjw_q    <= cbab_pkg::PRE_SJW;
			bt_silent_q <= (ab_q == AB_HUNT) || restart;
			bt_valid_q  <= !restart;
		end
	end

	// ----------------------------------------------------------------
	// Acceptance filters
	// ----------------------------------------------------------------
	logic [N_FLT-1:0] hit;      // Per filter match
	logic             pass;     // Message forwarded

	generate
		for (genvar i = 0; i < N_FLT; i++)
		begin : g_flt
			assign hit[i] = flt_en[i] && (((rx_msg_data[cbab_pkg::ID_W-1:0]
				^ flt_id[i*cbab_pkg::ID_W +: cbab_pkg::ID_W])
				& flt_mask[i*cbab_pkg::ID_W +: cbab_pkg::ID_W]) == '0);
		end
	endgenerate

	// No filter enabled forwards everything
	assign pass = (flt_en == '0) || (hit != '0);

	// ----------------------------------------------------------------
	// Transmit queue
	// ----------------------------------------------------------------
	// Messages are stored whole, so rate conversion needs no re-timing here.
	cbab_fifo_if #(.W(MSG_W)) q ();

	cbab_tx_e    tx_q;          // Radio sender state
	logic [1:0]  tries_q;       // Retries used
	logic        tx_load;       // Sender takes the head
	logic        ovf_drop;      // Oldest dropped to make room

	assign q.in_valid = rx_msg_valid && pass && (ab_q != AB_HUNT);
	assign q.in_data  = rx_msg_data;
	assign tx_load    = (tx_q == TX_IDLE) && q.out_valid && link_up;
	assign ovf_drop   = q.in_valid && q.out_valid && !tx_load && !q.in_ready;
	assign q.out_ready = tx_load || ovf_drop;

	cbab_fifo #(
		.W     (MSG_W),
		.DEPTH (DEPTH)
	) u_fifo (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.f       (q)
	);

	// Overflow pulse, one cycle per discarded message
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			ovf_drop_q <= 1'b0;
		else
			ovf_drop_q <= ovf_drop;
	end

	// ----------------------------------------------------------------
	// Radio sender with bounded retries
	// ----------------------------------------------------------------
	// The head is copied and popped at once, so an overflow never steals
	// the message currently in flight.
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			tx_q          <= TX_IDLE;
			tries_q       <= '0;
			radio_valid_q <= 1'b0;
			radio_data_q  <= '0;
			retry_drop_q  <= 1'b0;
		end
		else
		begin
			retry_drop_q <= 1'b0;
			case (tx_q)
				TX_IDLE:
				begin
					if (tx_load)
					begin
						radio_data_q  <= q.out_data;
						radio_valid_q <= 1'b1;
						tries_q       <= '0;
						tx_q          <= TX_SEND;
					end
				end
				TX_SEND:
				begin
					if (radio_ready)
					begin
						radio_valid_q <= 1'b0;
						tx_q          <= TX_WAIT;
					end
				end
				TX_WAIT:
				begin
					if (radio_ack)
						tx_q <= TX_IDLE;
					else if (radio_nak)
					begin
						if (tries_q == cbab_pkg::MAX_RETRY)
						begin
							retry_drop_q <= 1'b1;
							tx_q         <= TX_IDLE;
						end
						else
						begin
							tries_q       <= tries_q + 2'h1;
							radio_valid_q <= 1'b1;
							tx_q          <= TX_SEND;
						end
					end
				end
				default: tx_q <= TX_IDLE;
			endcase
		end
	end

endmodule

`default_nettype wire

// file: tb/cbab_seg_model.sv
// Model of the other nodes on the local segment, as the node's controller sees them.
// Assumes the bench asks for one frame at a time on frame_req.
`timescale 1ns/100ps
`default_nettype none

module cbab_seg_model (
	input  wire logic       sys_clk,
	input  wire logic       frame_req,
	input  wire logic [9:0] bus_brp,
	input  wire logic [9:0] bt_brp_q,
	input  wire logic       bt_valid_q,
	output logic            ctl_frame_ok,
	output logic            ctl_frame_err
);
	// one frame per request keeps load low
	// clean only at the segment's rate
	always @(posedge sys_clk)
	begin
		ctl_frame_ok <= frame_req && bt_valid_q && bt_brp_q === bus_brp;
		ctl_frame_err <= frame_req && !(bt_valid_q && bt_brp_q === bus_brp);
	end
endmodule

`default_nettype wire

// file: tb/cbab_node_checker.sv
// Concurrent checks on the node's top-level ports, attached by bind.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none

module cbab_node_checker #(
	parameter int MSG_W = cbab_pkg::MSG_W
) (
	input wire logic                        sys_clk,
	input wire logic                        sys_rst,
	input wire logic [2:0]                  cfg_rate_sel,
	input wire logic                        cfg_cust_defined,
	input wire logic                        ctl_frame_ok,
	input wire logic                        ctl_frame_err,
	input wire logic                        peer_rate_valid,
	input wire logic [1:0]                  peer_rate,
	input wire logic                        rx_msg_valid,
	input wire logic                        radio_ready,
	input wire logic                        radio_valid_q,
	input wire logic [MSG_W-1:0]            radio_data_q,
	input wire logic [cbab_pkg::BRP_W-1:0]  bt_brp_q,
	input wire logic [4:0]                  bt_tseg1_q,
	input wire logic [3:0]                  bt_tseg2_q,
	input wire logic                        bt_silent_q,
	input wire logic                        bt_valid_q,
	input wire logic                        rate_locked_q,
	input wire logic [1:0]                  local_rate_q,
	input wire logic                        rate_from_peer_q,
	input wire logic                        ovf_drop_q
);
	// ----------------------------------------------------------------
	// Setup
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);

	// Hunting: autobaud selected and no rate held yet
	logic hunt;
	assign hunt = cfg_rate_sel == cbab_pkg::SEL_AUTO && !rate_locked_q;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	// reset hunts at 1M
	reset_default_a: assert property (
		$fell(sys_rst) |-> !rate_locked_q && bt_silent_q && bt_brp_q == cbab_pkg::BRP_1M)
		else $error("reset state wrong");
	preset_lock_a: assert property (
		$changed(cfg_rate_sel) && cfg_rate_sel < 3'h4
		|=> rate_locked_q && local_rate_q == $past(cfg_rate_sel[1:0]))
		else $error("preset not taken");
	custom_fallback_a: assert property (
		$changed(cfg_rate_sel) && cfg_rate_sel == cbab_pkg::SEL_CUSTOM && !cfg_cust_defined
		|=> ##1 bt_valid_q && !bt_silent_q && bt_brp_q == cbab_pkg::BRP_1M)
		else $error("custom fallback wrong");
	preset_point_a: assert property (
		bt_valid_q && cfg_rate_sel != cbab_pkg::SEL_CUSTOM && $past(cfg_rate_sel, 2) == cfg_rate_sel
		|-> bt_tseg1_q == cbab_pkg::PRE_TSEG1 && bt_tseg2_q == cbab_pkg::PRE_TSEG2)
		else $error("preset segments wrong");
	hunt_silent_a: assert property (
		hunt |-> bt_silent_q) else $error("drives bus while hunting");
	frame_lock_a: assert property (
		hunt && $stable(cfg_rate_sel) && ctl_frame_ok |=> rate_locked_q && !rate_from_peer_q)
		else $error("no lock on clean frame");
	err_hunt_a: assert property (
		hunt && $stable(cfg_rate_sel) && ctl_frame_err && !ctl_frame_ok && !peer_rate_valid
		|=> !rate_locked_q) else $error("hunt left on error");
	peer_adopt_a: assert property (
		$rose(rate_from_peer_q) |-> rate_locked_q && $past(peer_rate_valid)
		&& local_rate_q == $past(peer_rate)) else $error("peer rate wrong");
	ovf_cause_a: assert property (
		ovf_drop_q |-> $past(rx_msg_valid)) else $error("discard without push");
	radio_hold_a: assert property (
		radio_valid_q && !radio_ready |=> radio_valid_q && $stable(radio_data_q))
		else $error("packet not held");

	// Main scenarios reached
	cover property (hunt && ctl_frame_ok);
	cover property ($rose(rate_from_peer_q));
	cover property (ovf_drop_q);
endmodule

bind cbab_node cbab_node_checker #(.MSG_W(MSG_W)) u_chk (.*);

`default_nettype wire

// file: tb/tb_top.sv
// Bench for one node: hunt, presets, custom timing, filters, retries, queue.
// Assumes the package, interface and design files are compiled first.
`timescale 1ns/100ps
`default_nettype none

module tb_top;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic         sys_clk = 1'b0;
	logic         sys_rst = 1'b1;
	logic [2:0]   cfg_rate_sel = cbab_pkg::SEL_AUTO;
	logic         cfg_cust_defined = 1'b0;
	logic [9:0]   cfg_cust_kbps = 10'h000;
	logic [4:0]   cfg_cust_tseg1 = 5'h00;
	logic [3:0]   cfg_cust_tseg2 = 4'h0;
	logic [1:0]   cfg_cust_sjw = 2'h1;
	logic         cfg_cust_silent = 1'b0;
	logic         link_up = 1'b1;
	logic         peer_rate_valid = 1'b0;
	logic [1:0]   peer_rate = 2'h0;
	logic [3:0]   flt_en = 4'h0;
	logic [115:0] flt_id = {4{29'h0000_0123}};
	logic [115:0] flt_mask = {4{29'h1fff_ffff}};
	logic         rx_msg_valid = 1'b0;
	logic [96:0]  rx_msg_data = 97'h0;
	logic         radio_ready = 1'b0;
	logic         radio_ack = 1'b0;
	logic         radio_nak = 1'b0;
	logic         frame_req = 1'b0;
	logic [9:0]   bus_brp = cbab_pkg::BRP_250K;  // Local segment runs at 250k
	logic         ctl_frame_ok, ctl_frame_err, radio_valid_q, bt_silent_q, bt_valid_q;
	logic         rate_locked_q, rate_from_peer_q, ovf_drop_q, retry_drop_q;
	logic [96:0]  radio_data_q, d;
	logic [9:0]   bt_brp_q;
	logic [4:0]   bt_tseg1_q;
	logic [3:0]   bt_tseg2_q;
	logic [1:0]   bt_sjw_q, local_rate_q;
	logic         got, ovf_seen = 1'b0, rdrop_seen = 1'b0;
	logic [28:0]  prev;
	logic [9:0]   brp_tab [4] = '{cbab_pkg::BRP_1M, cbab_pkg::BRP_500K,
		cbab_pkg::BRP_250K, cbab_pkg::BRP_125K};
	int           fails = 0, cmp_count = 0, k;

	// 200 MHz clock
	always #2.5 sys_clk = ~sys_clk;

	// Short adoption wait so the peer path is reached quickly
	cbab_node #(.ADOPT_CYC(32'h0000_00c8)) dut (.*);
	cbab_seg_model seg (.*);

	// Drop pulses are short; remember that they were seen
	always @(posedge sys_clk)
	begin
		if (ovf_drop_q === 1'b1)
			ovf_seen <= 1'b1;
		if (retry_drop_q === 1'b1)
			rdrop_seen <= 1'b1;
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [96:0] got_v, input logic [96:0] exp_v);
		cmp_count++;
		if (got_v !== exp_v)
		begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got_v, exp_v);
		end
	endtask

	// Waits edges, then lets their updates land before sampling
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic frame();
		@(posedge sys_clk);
		frame_req <= 1'b1;
		@(posedge sys_clk);
		frame_req <= 1'b0;
		cyc(4);
	endtask

	// One local message; back-to-back calls keep valid high
	task automatic send(input logic [28:0] id, input logic last);
		@(posedge sys_clk);
		rx_msg_valid <= 1'b1;
		rx_msg_data <= {35'h0, id, 4'h8, id};
		if (last)
		begin
			@(posedge sys_clk);
			rx_msg_valid <= 1'b0;
		end
	endtask

	// Radio side: accept the offered packet, then answer ack or nak
	task automatic take(input logic ack, output logic found, output logic [96:0] dv);
		cyc(1);
		for (int n = 0; n < 40 && radio_valid_q !== 1'b1; n++)
			cyc(1);
		found = (radio_valid_q === 1'b1);
		dv = radio_data_q;
		if (found)
		begin
			@(posedge sys_clk);
			radio_ready <= 1'b1;
			@(posedge sys_clk);
			radio_ready <= 1'b0;
			repeat (2) @(posedge sys_clk);
			radio_ack <= ack;
			radio_nak <= !ack;
			@(posedge sys_clk);
			radio_ack <= 1'b0;
			radio_nak <= 1'b0;
		end
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (6) @(posedge sys_clk);
		sys_rst <= 1'b0;
		cyc(1);
		chk(bt_brp_q, cbab_pkg::BRP_1M);
		chk({rate_locked_q, bt_silent_q}, 2'h1);
		// Frames fail at 1M and 500k before locking at 250k
		for (k = 0; k < 6 && rate_locked_q !== 1'b1; k++)
			frame();
		chk(local_rate_q, 2'h2);
		chk({bt_brp_q, bt_silent_q}, {cbab_pkg::BRP_250K, 1'b0});
		// Filter 0 passes only identifier 0x123
		@(posedge sys_clk);
		flt_en <= 4'h1;
		send(29'h0000_0124, 1'b1);
		cyc(4);
		chk(radio_valid_q, 1'b0);
		send(29'h0000_0123, 1'b1);
		take(1'b1, got, d);
		chk(d, {35'h0, 29'h0000_0123, 4'h8, 29'h0000_0123});
		@(posedge sys_clk);
		flt_en <= 4'h0;
		// First try and two retries, all refused
		send(29'h0000_0077, 1'b1);
		for (k = 0; k < 3; k++)
		begin
			take(1'b0, got, d);
			chk({got, d[28:0]}, {1'b1, 29'h0000_0077});
		end
		cyc(10);
		chk({radio_valid_q, rdrop_seen}, 2'h1);
		// Burst of eleven with the radio stalled overflows the queue
		for (k = 1; k < 12; k++)
			send(k[28:0], k == 11);
		cyc(2);
		chk(ovf_seen, 1'b1);
		prev = 29'h0;
		got = 1'b1;
		for (k = 0; k < 12 && got; k++)
		begin
			take(1'b1, got, d);
			if (got)
			begin
				chk(d[28:0] > prev, 1'b1);
				prev = d[28:0];
			end
		end
		chk(prev, 29'h0000_000b);
		// Each fixed preset
		for (k = 0; k < 4; k++)
		begin
			@(posedge sys_clk);
			cfg_rate_sel <= 3'(k);
			cyc(4);
			chk({local_rate_q, bt_brp_q}, {2'(k), brp_tab[k]});
			chk({bt_tseg1_q, bt_tseg2_q}, {cbab_pkg::PRE_TSEG1, cbab_pkg::PRE_TSEG2});
		end
		@(posedge sys_clk);
		cfg_rate_sel <= cbab_pkg::SEL_CUSTOM;
		cyc(4);
		chk(bt_brp_q, cbab_pkg::BRP_1M);
		// 250 kbit/s with 16 quanta gives a divisor of 50
		@(posedge sys_clk);
		cfg_cust_defined <= 1'b1;
		cfg_cust_kbps <= 10'h0fa;
		cfg_cust_tseg1 <= 5'h0c;
		cfg_cust_tseg2 <= 4'h3;
		cfg_cust_silent <= 1'b1;
		cyc(4);
		for (k = 0; k < 1100 && bt_valid_q !== 1'b1; k++)
			cyc(1);
		chk(bt_brp_q, 10'h032);
		chk({bt_tseg1_q, bt_tseg2_q, bt_sjw_q}, {5'h0c, 4'h3, 2'h1});
		chk(bt_silent_q, 1'b1);
		// Back to autobaud with a silent segment: the peer decides
		@(posedge sys_clk);
		cfg_rate_sel <= cbab_pkg::SEL_AUTO;
		peer_rate_valid <= 1'b1;
		peer_rate <= 2'h3;
		cyc(2);
		for (k = 0; k < 600 && rate_locked_q !== 1'b1; k++)
			cyc(1);
		chk(rate_from_peer_q, 1'b1);
		chk(local_rate_q, 2'h3);
		@(posedge sys_clk);
		link_up <= 1'b0;
		peer_rate_valid <= 1'b0;
		cyc(20);
		@(posedge sys_clk);
		link_up <= 1'b1;
		cyc(4);
		chk({rate_locked_q, local_rate_q}, 3'h7);
		report_and_stop();
	end

	// Whole run is a few hundred cycles
	initial
	begin
		#100000;
		fails++;
		report_and_stop();
	end
endmodule

`default_nettype wire
